// file: rtl/tpic_pkg.sv
/*
 Package for the test-pattern injection control block: register
 indices, field positions, reset values, widths and carrier types.
 Assumes a 16-bit register port and one crossing per clock cycle.
*/
package tpic_pkg;

	// ==================================================================
	// Register port
	// ==================================================================
	localparam int          REG_W          = 16;
	localparam int          SEL_W          = 3;
	localparam logic [2:0]  SEL_FE_CFG     = 3'h0;
	localparam logic [2:0]  SEL_CORE_CFG   = 3'h1;
	localparam logic [2:0]  SEL_RO_CFG     = 3'h2;
	localparam logic [2:0]  SEL_STUB_STAT  = 3'h3;
	localparam logic [2:0]  SEL_RUN_REQ    = 3'h4;

	// ==================================================================
	// Field positions
	// ==================================================================
	localparam int BIT_LOOP        = 15;
	localparam int BIT_FE_ALIGN    = 13;
	localparam int BIT_FE_TX       = 12;
	localparam int BIT_FE_TIMING   = 11;
	localparam int BIT_CORE_BARREL = 15;
	localparam int BIT_CORE_ENDCAP = 14;
	localparam int BIT_CORE_TRACK  = 13;
	localparam int BIT_CORE_TIMING = 12;
	localparam int BIT_RO_TX       = 12;
	localparam int BIT_STAT_FULL   = 15;
	localparam int BIT_STAT_EMPTY  = 14;
	localparam int BIT_REQ_PERSIST = 15;
	localparam int BIT_REQ_ARM     = 13;

	// Writable bit masks; all other bits ignore writes and read zero
	localparam logic [15:0] MASK_FE   = 16'hB9FF;
	localparam logic [15:0] MASK_CORE = 16'hF1FF;
	localparam logic [15:0] MASK_RO   = 16'h93FF;
	localparam logic [15:0] MASK_REQ  = 16'hA000;
	localparam logic [15:0] CFG_RESET = 16'h0000;

	// ==================================================================
	// Windows and stub memory
	// ==================================================================
	localparam int          FE_WIN_W   = 9;
	localparam int          CORE_WIN_W = 9;
	localparam int          RO_WIN_W   = 10;
	localparam int          CNT_W      = 11;
	localparam logic [10:0] STUB_DEPTH = 11'h400;
	localparam int          LINK_N     = 15;

	// ==================================================================
	// Carrier types
	// ==================================================================
	typedef struct packed {
		logic orbit_mark;
		logic bunch_number_bit_high;
		logic bunch_number_bit_low;
	} tpic_timing_t;

	typedef struct packed {
		logic [2:0]  sel;
		logic        wr;
		logic [15:0] wdata;
	} tpic_reg_req_t;

endpackage

// file: rtl/tpic_window.sv
/*
 Injection window sequencer: on start it stays active for len+1 steps.
 Assumes start and step are single-cycle qualifiers on clk.
*/
`timescale 1ns/1ps
module tpic_window #(
	parameter int CW = 9
) (
	input  wire logic          clk,
	input  wire logic          reset,
	input  wire logic          ce,
	input  wire logic          start,
	input  wire logic          step,
	input  wire logic [CW-1:0] len,
	output logic               active
);
	import tpic_pkg::*;

	// ==================================================================
	// State
	// ==================================================================
	typedef enum logic [0:0] {
		TPIC_W_IDLE = 1'b0,
		TPIC_W_RUN  = 1'b1
	} tpic_wstate_t;

	tpic_wstate_t  state_q;
	tpic_wstate_t  state_d;
	logic [CW-1:0] count_q;
	logic [CW-1:0] count_d;

	// Window of len+1 steps, restart reloads
	always_comb begin
		state_d = state_q;
		count_d = count_q;
		case (state_q)
			TPIC_W_IDLE: begin
				if (start) begin
					state_d = TPIC_W_RUN;
					count_d = len;
				end
			end
			TPIC_W_RUN: begin
				if (start) begin
					count_d = len;
				end else if (step) begin
					if (count_q == '0) begin
						state_d = TPIC_W_IDLE;
					end else begin
						count_d = count_q - 1'b1;
					end
				end
			end
			default: begin
				state_d = TPIC_W_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			state_q <= TPIC_W_IDLE;
			count_q <= '0;
		end else if (ce) begin
			state_q <= state_d;
			count_q <= count_d;
		end
	end

	assign active = (state_q == TPIC_W_RUN);

endmodule

// file: rtl/tpic_top.sv
/*
 Test-pattern injection control: configuration registers of the
 front-end, core and readout-link chips, the run request, the window
 sequencers, timing override and the common stub memory status.
 Assumes a synchronous register port and one crossing per clock.
*/
`timescale 1ns/1ps

// Functional notes
// [R1] Front two, readout one, core three injection points
// [R2] Loop bit writes injected data back to memory
// [R3] Front-end bit 13 enables alignment output injection
// [R4] Bit 12 enables transmitter injection
// [R5] Timing bit replaces path timing with pattern timing
// [R6] Timing injection makes pattern timing bits valid
// [R7] Front-end window N injects N+1 crossings
// [R8] Core bit enables barrel stub injection
// [R9] Core bit enables endcap stub injection
// [R10] Core bit enables track output injection
// [R11] Core window N+1 crossings when any enable
// [R12] Readout window N injects N+1 patterns
// [R13] Unused config bits ignore writes, read zero
// [R14] One read-only status for common stub memory
// [R15] Stub memory holds 1024 sixteen-bit words
// [R16] Count in bits 10:0, full bit 15
// [R17] Empty bit 14 set when memory empty
// [R18] Self-test drives all 15 optical outputs
// [R19] Software sequences mode, reset, load, inject, compare
// [R20] Timing loopback routes front patterns to barrel spy
// [R21] One-time request self-clears, persistent keeps firing
// [R22] Enabled points inject concurrently over one window
module tpic_top (
	input  wire logic                        clk,
	input  wire logic                        reset,
	input  wire logic                        ce,
	input  wire tpic_pkg::tpic_reg_req_t     reg_req,
	output logic [tpic_pkg::REG_W-1:0]       reg_rdata,
	input  wire logic                        test_run_command,
	input  wire logic                        pattern_inject_command,
	input  wire logic                        ro_pattern_sent,
	input  wire logic                        stub_mem_load,
	input  wire logic                        stub_mem_read,
	input  wire tpic_pkg::tpic_timing_t      path_timing,
	input  wire tpic_pkg::tpic_timing_t      pattern_timing,
	output tpic_pkg::tpic_timing_t           fe_timing_out,
	output logic                             fe_inject_align_out,
	output logic                             fe_inject_tx,
	output logic                             fe_writeback,
	output logic                             core_inject_barrel,
	output logic                             core_inject_endcap,
	output logic                             core_inject_track,
	output logic                             core_writeback,
	output logic                             ro_inject_tx,
	output logic                             ro_writeback,
	output logic [tpic_pkg::LINK_N-1:0]      optical_self_test,
	output logic                             barrel_loop_route,
	output logic [tpic_pkg::CNT_W-1:0]       stub_memory_word_count,
	output logic                             stub_memory_full,
	output logic                             stub_memory_empty
);
	import tpic_pkg::*;

	// ==================================================================
	// Helpers
	// ==================================================================
	function automatic logic sel_hit(input tpic_reg_req_t r,
	                                 input logic [2:0] s);
		sel_hit = r.wr && (r.sel == s);
	endfunction

	// ==================================================================
	// Configuration registers
	// ==================================================================
	logic [REG_W-1:0] fe_cfg_q;
	logic [REG_W-1:0] core_cfg_q;
	logic [REG_W-1:0] ro_cfg_q;
	logic             req_persist_q;
	logic             req_arm_q;
	logic             req_arm_d;

	wire wr_fe   = sel_hit(reg_req, SEL_FE_CFG);
	wire wr_core = sel_hit(reg_req, SEL_CORE_CFG);
	wire wr_ro   = sel_hit(reg_req, SEL_RO_CFG);
	wire wr_req  = sel_hit(reg_req, SEL_RUN_REQ);

	always_ff @(posedge clk) begin
		if (reset) begin
			fe_cfg_q   <= CFG_RESET;
			core_cfg_q <= CFG_RESET;
			ro_cfg_q   <= CFG_RESET;
		end else if (ce) begin
			if (wr_fe) begin
				fe_cfg_q <= reg_req.wdata & MASK_FE; // [R13]
			end
			if (wr_core) begin
				core_cfg_q <= reg_req.wdata & MASK_CORE; // [R13]
			end
			if (wr_ro) begin
				ro_cfg_q <= reg_req.wdata & MASK_RO; // [R13]
			end
		end
	end

	// ==================================================================
	// Field decode
	// ==================================================================
	wire fe_loop     = fe_cfg_q[BIT_LOOP]; // [R2]
	wire fe_align_en = fe_cfg_q[BIT_FE_ALIGN]; // [R3]
	wire fe_tx_en    = fe_cfg_q[BIT_FE_TX]; // [R4]
	wire fe_time_en  = fe_cfg_q[BIT_FE_TIMING]; // [R5]
	wire [FE_WIN_W-1:0] fe_win = fe_cfg_q[FE_WIN_W-1:0];

	wire core_loop   = core_cfg_q[BIT_LOOP]; // [R2]
	wire core_bar_en = core_cfg_q[BIT_CORE_BARREL]; // [R8]
	wire core_end_en = core_cfg_q[BIT_CORE_ENDCAP]; // [R9]
	wire core_trk_en = core_cfg_q[BIT_CORE_TRACK]; // [R10]
	wire [CORE_WIN_W-1:0] core_win = core_cfg_q[CORE_WIN_W-1:0];

	wire ro_loop  = ro_cfg_q[BIT_LOOP]; // [R2]
	wire ro_tx_en = ro_cfg_q[BIT_RO_TX]; // [R4]
	wire [RO_WIN_W-1:0] ro_win = ro_cfg_q[RO_WIN_W-1:0];

	wire fe_any   = fe_align_en | fe_tx_en; // [R1]
	wire core_any = core_bar_en | core_end_en | core_trk_en; // [R1] [R11]

	// ==================================================================
	// Run request
	// ==================================================================
	wire req_fire = req_arm_q & pattern_inject_command;
	wire run      = test_run_command | req_fire;

	// Software arming wins over the self-clear in the same cycle
	always_comb begin
		req_arm_d = req_arm_q;
		if (req_fire && !req_persist_q) begin
			req_arm_d = 1'b0; // [R21]
		end
		if (wr_req) begin
			req_arm_d = reg_req.wdata[BIT_REQ_ARM];
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			req_persist_q <= 1'b0;
			req_arm_q     <= 1'b0;
		end else if (ce) begin
			if (wr_req) begin
				req_persist_q <= reg_req.wdata[BIT_REQ_PERSIST]; // [R21]
			end
			req_arm_q <= req_arm_d;
		end
	end

	// ==================================================================
	// Injection windows
	// ==================================================================
	logic fe_active;
	logic core_active;
	logic ro_active;

	// Crossing windows step every cycle
	tpic_window #(
		.CW     (FE_WIN_W)
	) u_fe_win (
		.clk    (clk),
		.reset  (reset),
		.ce     (ce),
		.start  (run & fe_any), // [R7]
		.step   (1'b1),
		.len    (fe_win),
		.active (fe_active)
	);

	tpic_window #(
		.CW     (CORE_WIN_W)
	) u_core_win (
		.clk    (clk),
		.reset  (reset),
		.ce     (ce),
		.start  (run & core_any), // [R11]
		.step   (1'b1),
		.len    (core_win),
		.active (core_active)
	);

	// Readout window counts individual patterns
	tpic_window #(
		.CW     (RO_WIN_W)
	) u_ro_win (
		.clk    (clk),
		.reset  (reset),
		.ce     (ce),
		.start  (run & ro_tx_en), // [R12]
		.step   (ro_pattern_sent), // [R12]
		.len    (ro_win),
		.active (ro_active)
	);

	// ==================================================================
	// Injection point outputs
	// ==================================================================
	wire fe_time_sel = fe_active & fe_time_en;
	tpic_timing_t timing_d;
	assign timing_d = fe_time_sel ? pattern_timing : path_timing; // [R5] [R6]

	always_ff @(posedge clk) begin
		if (reset) begin
			fe_inject_align_out <= 1'b0;
			fe_inject_tx        <= 1'b0;
			fe_writeback        <= 1'b0;
			core_inject_barrel  <= 1'b0;
			core_inject_endcap  <= 1'b0;
			core_inject_track   <= 1'b0;
			core_writeback      <= 1'b0;
			ro_inject_tx        <= 1'b0;
			ro_writeback        <= 1'b0;
			fe_timing_out       <= '0;
			barrel_loop_route   <= 1'b0;
			optical_self_test   <= '0;
		end else if (ce) begin
			fe_inject_align_out <= fe_active & fe_align_en; // [R3] [R22]
			fe_inject_tx        <= fe_active & fe_tx_en; // [R4] [R22]
			fe_writeback        <= fe_active & fe_loop; // [R2]
			core_inject_barrel  <= core_active & core_bar_en; // [R8] [R22]
			core_inject_endcap  <= core_active & core_end_en; // [R9] [R22]
			core_inject_track   <= core_active & core_trk_en; // [R10] [R22]
			core_writeback      <= core_active & core_loop; // [R2]
			ro_inject_tx        <= ro_active & ro_tx_en; // [R4]
			ro_writeback        <= ro_active & ro_loop; // [R2]
			fe_timing_out       <= timing_d; // [R5]
			barrel_loop_route   <= fe_time_sel; // [R20]
			optical_self_test   <= {LINK_N{core_active & core_trk_en}}; // [R18]
		end
	end

	// ==================================================================
	// Common stub memory status
	// ==================================================================
	logic [CNT_W-1:0] stub_cnt_q;
	logic [CNT_W-1:0] stub_cnt_d;

	wire stub_full  = (stub_cnt_q == STUB_DEPTH); // [R15] [R16]
	wire stub_empty = (stub_cnt_q == '0); // [R17]
	// Writeback returns each read word to the memory
	wire stub_wb    = core_active & core_end_en & core_loop; // [R2]
	wire stub_rd    = stub_mem_read & ~stub_empty;
	wire stub_wr    = (stub_mem_load | (stub_rd & stub_wb)) & ~stub_full;

	always_comb begin
		stub_cnt_d = stub_cnt_q;
		if (stub_wr && !stub_rd) begin
			stub_cnt_d = stub_cnt_q + 1'b1;
		end else if (stub_rd && !stub_wr && !stub_wb) begin
			stub_cnt_d = stub_cnt_q - 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			stub_cnt_q             <= '0;
			stub_memory_word_count <= '0;
			stub_memory_full       <= 1'b0;
			stub_memory_empty      <= 1'b1;
		end else if (ce) begin
			stub_cnt_q             <= stub_cnt_d;
			stub_memory_word_count <= stub_cnt_d; // [R16]
			stub_memory_full       <= (stub_cnt_d == STUB_DEPTH); // [R16]
			stub_memory_empty      <= (stub_cnt_d == '0); // [R17]
		end
	end

	// ==================================================================
	// Register read
	// ==================================================================
	logic [REG_W-1:0] stat_word;
	logic [REG_W-1:0] req_word;
	logic [REG_W-1:0] rd_mux;

	always_comb begin
		stat_word                 = '0; // [R14]
		stat_word[CNT_W-1:0]      = stub_cnt_q; // [R16]
		stat_word[BIT_STAT_FULL]  = stub_full; // [R16]
		stat_word[BIT_STAT_EMPTY] = stub_empty; // [R17]
		req_word                  = '0;
		req_word[BIT_REQ_PERSIST] = req_persist_q;
		req_word[BIT_REQ_ARM]     = req_arm_q;
		case (reg_req.sel)
			SEL_FE_CFG:    rd_mux = fe_cfg_q;
			SEL_CORE_CFG:  rd_mux = core_cfg_q;
			SEL_RO_CFG:    rd_mux = ro_cfg_q;
			SEL_STUB_STAT: rd_mux = stat_word;
			SEL_RUN_REQ:   rd_mux = req_word;
			default:       rd_mux = '0;
		endcase
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			reg_rdata <= '0;
		end else if (ce) begin
			reg_rdata <= rd_mux;
		end
	end

endmodule

// file: dv/tpic_top_asserts.sv
/*
 Port checker for tpic_top: status flags, window start, timing select,
 writeback, self-test drive and read-back of unused bits.
 Assumes ce may drop between transfers; bound to every tpic_top below.
*/
`timescale 1ns/1ps
module tpic_top_asserts
	import tpic_pkg::*;
(
	input wire logic                   clk,
	input wire logic                   reset,
	input wire logic                   ce,
	input wire tpic_pkg::tpic_reg_req_t reg_req,
	input wire logic [15:0]            reg_rdata,
	input wire logic                   test_run_command,
	input wire logic                   pattern_inject_command,
	input wire tpic_pkg::tpic_timing_t path_timing,
	input wire tpic_pkg::tpic_timing_t pattern_timing,
	input wire tpic_pkg::tpic_timing_t fe_timing_out,
	input wire logic                   fe_inject_align_out,
	input wire logic                   fe_inject_tx,
	input wire logic                   fe_writeback,
	input wire logic                   core_inject_barrel,
	input wire logic                   core_inject_track,
	input wire logic                   ro_inject_tx,
	input wire logic [14:0]            optical_self_test,
	input wire logic                   barrel_loop_route,
	input wire logic [10:0]            stub_memory_word_count,
	input wire logic                   stub_memory_full,
	input wire logic                   stub_memory_empty
);
	// ==============================================================
	// Properties
	// ==============================================================
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	wire logic cmd = test_run_command | pattern_inject_command;

	empty_flag_a: assert property (
		stub_memory_empty == (stub_memory_word_count == 11'h000))
		else $error("empty flag disagrees with count");
	full_flag_a: assert property (
		stub_memory_full == (stub_memory_word_count == STUB_DEPTH))
		else $error("full flag disagrees with count");
	count_cap_a: assert property (
		stub_memory_word_count <= STUB_DEPTH)
		else $error("word count above capacity");
	fe_start_a: assert property (
		$rose(fe_inject_align_out) |-> $past(cmd, 2))
		else $error("front injection began without command");
	core_start_a: assert property (
		$rose(core_inject_barrel) |-> $past(cmd, 2))
		else $error("core injection began without command");
	ro_start_a: assert property (
		$rose(ro_inject_tx) |-> $past(cmd, 2))
		else $error("readout injection began without command");
	timing_sel_a: assert property (
		!$past(reset) && $past(ce) |->
		fe_timing_out == (barrel_loop_route ?
		$past(pattern_timing) : $past(path_timing)))
		else $error("timing bits from wrong source");
	wb_inject_a: assert property (
		fe_writeback |-> fe_inject_align_out || fe_inject_tx)
		else $error("writeback without injection");
	self_test_a: assert property (
		optical_self_test == {LINK_N{core_inject_track}})
		else $error("optical outputs not driven together");
	fe_unused_a: assert property (
		!$past(reset) && $past(reg_req.sel) == SEL_FE_CFG |->
		(reg_rdata & ~MASK_FE) == 16'h0000)
		else $error("unused front config bits read nonzero");
	stat_zero_a: assert property (
		!$past(reset) && $past(reg_req.sel) == SEL_STUB_STAT |->
		reg_rdata[13:11] == 3'h0)
		else $error("status bits 13 to 11 nonzero");
endmodule
bind tpic_top tpic_top_asserts u_chk (.clk, .reset, .ce, .reg_req,
	.reg_rdata, .test_run_command, .pattern_inject_command, .path_timing,
	.pattern_timing, .fe_timing_out, .fe_inject_align_out, .fe_inject_tx,
	.fe_writeback, .core_inject_barrel, .core_inject_track, .ro_inject_tx,
	.optical_self_test, .barrel_loop_route, .stub_memory_word_count,
	.stub_memory_full, .stub_memory_empty);

// file: dv/tpic_host.sv
/*
 Host software model: register writes and reads, fast-control pulses.
 Assumes read data is registered one cycle after the select.
*/
`timescale 1ns/1ps
module tpic_host
	import tpic_pkg::*;
(
	input  wire logic                    clk,
	input  wire logic [15:0]             reg_rdata,
	output tpic_pkg::tpic_reg_req_t      reg_req,
	output logic                         test_run_command,
	output logic                         pattern_inject_command
);
	// ==============================================================
	// Bus and command tasks
	// ==============================================================
	initial begin
		reg_req = '0;
		test_run_command = 1'b0;
		pattern_inject_command = 1'b0;
	end
	// Config written before the inject command
	task wr(input logic [2:0] s, input logic [15:0] d);
		@(posedge clk);
		reg_req <= '{sel: s, wr: 1'b1, wdata: d};
		@(posedge clk);
		reg_req.wr <= 1'b0;
	endtask
	// Read back after the run for comparison
	task rd(input logic [2:0] s, output logic [15:0] d);
		@(posedge clk);
		reg_req.sel <= s;
		@(posedge clk);
		@(negedge clk);
		d = reg_rdata;
	endtask
	task pulse(input logic inj);
		@(posedge clk);
		if (inj) begin
			pattern_inject_command <= 1'b1;
		end else begin
			test_run_command <= 1'b1;
		end
		@(posedge clk);
		pattern_inject_command <= 1'b0;
		test_run_command <= 1'b0;
	endtask
endmodule

// file: dv/tpic_top_tb.sv
/*
 Testbench for tpic_top with an integer reference of the registers,
 windows and stub memory count. Assumes the checker binds itself.
*/
`timescale 1ns/1ps
module tpic_top_tb;
	import tpic_pkg::*;
	logic clk = 0, reset = 1, ce = 1, ro_step = 0, ld = 0, rdp = 0;
	tpic_timing_t pth = '0, pat = '0, fto, pth_q = '0, pat_q = '0;
	tpic_reg_req_t reg_req;
	logic [15:0] reg_rdata, rd;
	logic trc, pic, fe_a, fe_t, fe_w, co_b, co_e, co_t, co_w;
	logic ro_t, ro_w, blr, full, empty;
	logic [14:0] opt;
	logic [10:0] wc;
	logic [15:0] cfg[5] = '{default: 16'h0000};
	logic [15:0] fe_v[6] = '{16'hB800, 16'h2000, 16'h1000, 0, 0, 16'h3000};
	logic [15:0] co_v[6] = '{0, 0, 0, 16'hE000, 16'h4000, 16'hA000};
	int fail_count = 0, n_compared = 0, cnt[11], stub = 0, n, e, tm = 0;
	wire logic [10:0] vec = {opt === 15'h7FFF, blr, ro_w, ro_t, co_w, co_t,
		co_e, co_b, fe_w, fe_t, fe_a};

	tpic_top DUT (.clk(clk), .reset(reset), .ce(ce), .reg_req(reg_req),
		.reg_rdata(reg_rdata), .test_run_command(trc),
		.pattern_inject_command(pic), .ro_pattern_sent(ro_step),
		.stub_mem_load(ld), .stub_mem_read(rdp), .path_timing(pth),
		.pattern_timing(pat), .fe_timing_out(fto),
		.fe_inject_align_out(fe_a), .fe_inject_tx(fe_t),
		.fe_writeback(fe_w), .core_inject_barrel(co_b),
		.core_inject_endcap(co_e), .core_inject_track(co_t),
		.core_writeback(co_w), .ro_inject_tx(ro_t), .ro_writeback(ro_w),
		.optical_self_test(opt), .barrel_loop_route(blr),
		.stub_memory_word_count(wc), .stub_memory_full(full),
		.stub_memory_empty(empty));
	tpic_host host (.clk(clk), .reg_rdata(reg_rdata), .reg_req(reg_req),
		.test_run_command(trc), .pattern_inject_command(pic));

	// ==============================================================
	// Clock, random timing bits, window counters
	// ==============================================================
	always #25 clk = ~clk;
	always @(posedge clk) begin
		pth_q <= pth;
		pat_q <= pat;
		pth <= 3'($urandom);
		pat <= 3'($urandom);
	end
	always @(negedge clk) begin
		foreach (cnt[i]) if (vec[i] === 1'b1) cnt[i]++;
		if (fto !== (blr ? pat_q : pth_q)) tm++;
	end

	// ==============================================================
	// Reference and compare tasks
	// ==============================================================
	task chk_reg(string what, logic [15:0] exp, logic [15:0] got);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task chk_cnt(string what, int exp, int got);
		n_compared++;
		if (got != exp) begin
			fail_count++;
			$display("Error %s expected %0d seen %0d", what, exp, got);
		end
	endtask
	task wrm(logic [2:0] s, logic [15:0] d);
		host.wr(s, d);
		case (s)
			0: cfg[0] = d & MASK_FE;
			1: cfg[1] = d & MASK_CORE;
			2: cfg[2] = d & MASK_RO;
			4: cfg[4] = d & MASK_REQ;
			default: ;
		endcase
	endtask
	task rdc(logic [2:0] s);
		host.rd(s, rd);
		if (s == 3) e = {stub == 1024, stub == 0, 3'h0, 11'(stub)};
		else e = s < 5 ? cfg[s] : 0;
		chk_reg("register", e[15:0], rd);
		if (s == 3)
			chk_reg("status", e[15:0], {full, empty, 3'h0, wc});
	endtask
	function int exp_n(int i, int k);
		logic b;
		case (i)
			0: b = cfg[0][13];
			1: b = cfg[0][12];
			2: b = cfg[0][15] & (cfg[0][13] | cfg[0][12]);
			3, 6: b = cfg[1][15];
			4: b = cfg[1][14];
			5, 10: b = cfg[1][13];
			9: b = cfg[0][11] & (cfg[0][13] | cfg[0][12]);
			default: b = 0;
		endcase
		return b ? k + 1 : 0;
	endfunction
	task run(logic inj, int k);
		cnt = '{default: 0};
		tm = 0;
		host.pulse(inj);
		repeat (k + 6) @(posedge clk);
	endtask
	task mem(logic load, int k);
		@(posedge clk);
		if (load) ld <= 1'b1;
		else rdp <= 1'b1;
		repeat (k) @(posedge clk);
		ld <= 1'b0;
		rdp <= 1'b0;
		stub = load ? (stub + k > 1024 ? 1024 : stub + k) :
			(stub < k ? 0 : stub - k);
	endtask
	task stop_test();
		$display("Compared %0d, mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask

	// ==============================================================
	// Scenarios
	// ==============================================================
	initial begin
		repeat (20000) @(posedge clk);
		fail_count++;
		stop_test();
	end
	initial begin
		void'($urandom(61463));
		repeat (5) @(posedge clk);
		reset <= 1'b0;
		for (int s = 0; s < 8; s++) rdc(s[2:0]);
		for (int s = 0; s < 8; s++) begin
			wrm(s[2:0], 16'($urandom));
			rdc(s[2:0]);
		end
		for (int i = 0; i < 6; i++) begin
			n = i == 0 ? 0 : i == 1 ? 511 : $urandom_range(60, 1);
			wrm(3'h2, 16'h0000);
			wrm(3'h0, fe_v[i] | 16'(n));
			wrm(3'h1, co_v[i] | 16'(n));
			run(1'b0, n);
			for (int b = 0; b < 11; b++) begin
				e = exp_n(b, n);
				if (b < 3) chk_cnt("fe", e, cnt[b]);
				else if (b < 7) chk_cnt("core", e, cnt[b]);
				else if (b < 9) chk_cnt("ro", e, cnt[b]);
				else if (b == 9) chk_cnt("route", e, cnt[b]);
				else chk_cnt("optical", e, cnt[b]);
			end
			chk_cnt("track", exp_n(5, n), cnt[5]);
			chk_cnt("timing", 0, tm);
		end
		wrm(3'h1, 16'h0000);
		wrm(3'h0, 16'h2002);
		for (int p = 0; p < 2; p++) begin
			wrm(3'h4, p ? 16'hA000 : 16'h2000);
			repeat (2) begin
				run(1'b1, 2);
				chk_cnt("request", cfg[4][13] ? 3 : 0, cnt[0]);
				if (!cfg[4][15]) cfg[4][13] = 1'b0;
			end
			rdc(3'h4);
		end
		wrm(3'h0, 16'h0000);
		wrm(3'h2, 16'h9003);
		host.pulse(1'b0);
		@(negedge clk);
		for (int k = 0; k < 4; k++) begin
			@(negedge clk);
			chk_reg("ro_tx", 16'h0003, {14'h0, ro_w, ro_t});
			@(posedge clk) ro_step <= 1'b1;
			@(posedge clk) ro_step <= 1'b0;
		end
		repeat (4) @(negedge clk);
		chk_reg("ro_tx", 16'h0000, {14'h0, ro_w, ro_t});
		mem(1'b1, 5);
		@(posedge clk) ce <= 1'b0;
		mem(1'b1, 3);
		ce <= 1'b1;
		stub = stub - 3;
		mem(1'b0, 2);
		rdc(3'h3);
		mem(1'b1, 1030);
		rdc(3'h3);
		mem(1'b0, 1021);
		rdc(3'h3);
		mem(1'b0, 10);
		rdc(3'h3);
		stop_test();
	end
endmodule
